// ===== logic/fsp_regs.svh
// Constants of the flash self-programming controller: register indices,
// field positions, command codes, timing figures and reset values.
// Assumes a single 200 MHz clock and an 8-bit AXI4-Lite byte address.
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// Register indices; byte address is four times the index
`define FSP_CSR_IDX 6'h37
`define FSP_PTR_IDX 6'h38
`define FSP_DATA_IDX 6'h39
`define FSP_CMD_IDX 6'h3A
`define FSP_LOAD_IDX 6'h3B
`define FSP_STAT_IDX 6'h3C

// Control/status bit positions
`define FSP_CSR_EN 0
`define FSP_CSR_ERASE 1
`define FSP_CSR_WRITE 2
`define FSP_CSR_LOCK 3
`define FSP_CSR_REEN 4
`define FSP_CSR_BUSY 6
`define FSP_CSR_IE 7
`define FSP_CSR_RST 8'h00

// Command patterns in the low five control bits
`define FSP_CMD_BUF 5'h01
`define FSP_CMD_ERASE 5'h03
`define FSP_CMD_WRITE 5'h05
`define FSP_CMD_LOCK 5'h09
`define FSP_CMD_REEN 5'h11

// Timed windows after the enable bit is set, in clock cycles
`define FSP_STORE_WIN 3'h4
`define FSP_LOAD_WIN 3'h3

// Pointer values for fuse and lock read back
`define FSP_PTR_FUSE_LO 16'h0000
`define FSP_PTR_LOCK 16'h0001
`define FSP_PTR_EXT 16'h0002
`define FSP_PTR_FUSE_HI 16'h0003

// Pointer page field and section limit
`define FSP_PAGE_MSB 13
`define FSP_PAGE_LSB 7
`define FSP_HALT_PAGE_MIN 7'h70

// Lock byte: only bits 5..0 are real, all unprogrammed at reset
`define FSP_LOCK_MASK 8'h3F
`define FSP_LOCK_RST 8'hFF

// Programming time window and clock period
`define FSP_T_WRITE_MIN_NS 3700000
`define FSP_T_WRITE_MAX_NS 4500000
`define FSP_CLK_NS 5

// AXI responses
`define FSP_RESP_OKAY 2'h0
`define FSP_RESP_SLVERR 2'h2

`endif

// ===== logic/fsp_pkg.sv
// Types of the flash self-programming controller.
// Assumes the constants header is included by the design module.
package fsp_pkg;

	// Sequencer states, Gray coded along idle -> run -> finish
	typedef enum logic [1:0] {
		FSP_IDLE = 2'b00,
		FSP_RUN = 2'b01,
		FSP_FINISH = 2'b11
	} fsp_state_e;

	// Kind of timed flash operation
	typedef enum logic [1:0] {
		FSP_OP_ERASE = 2'b00,
		FSP_OP_WRITE = 2'b01,
		FSP_OP_LOCK = 2'b10
	} fsp_kind_e;

	// Operation presented to the flash array
	typedef struct packed {
		logic busy;
		fsp_kind_e kind;
		logic [6:0] page;
		logic halting;
	} fsp_op_s;

	// Fuse bytes as held by the fuse cells
	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic [7:0] ext;
	} fsp_fuse_s;

endpackage

// ===== logic/fsp_ctrl.sv
// Flash self-programming controller with an AXI4-Lite register port.
// Assumes the program memory byte at the pointer arrives on
// prog_rdata_i, and that fuse cells and the EEPROM busy flag are levels.
//
// Overview of operation
// - Readable section write keeps halting section readable.
// - Write to halting section halts the CPU.
// - Interrupt asserted while enable bit reads clear.
// - Erase or write blocks readable section reads.
// - Busy flag set while section unavailable.
// - Re-enable command clears the busy flag.
// - Lock pattern plus store within four cycles.
// - Zero in bits 5..2 programs boot lock.
// - Lock programming leaves whole flash readable.
// - EEPROM write refuses stores and fuse reads.
// - Lock byte read at pointer 0001.
// - Lock-set and enable auto-clear on timeout/completion.
// - Bits clear: loads return program memory.
// - Pointer 0000 returns low fuse byte.
// - Pointer 0003 returns high fuse byte.
// - Pointer 0002 returns extended fuse byte.
// - Programmed reads zero, unprogrammed reads one.
// - Write runs to completion across CPU reset.
// - Operations last between 3.7 and 4.5 ms.
// - Control/status register index 0x37 layout.
// - Page from pointer bits 13..7.
// - Interrupt also needs global interrupt enable.
`timescale 1ns/10ps
`include "fsp_regs.svh"

module fsp_ctrl
	import fsp_pkg::*;
#(
	// Operation length in cycles, from the minimum write time and clock period
	parameter int WRITE_CYCLES =
		(`FSP_T_WRITE_MIN_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic cpu_rst_i,
	input wire logic global_irq_en_i,
	input wire logic eeprom_write_busy_i,
	input wire logic [7:0] prog_rdata_i,
	input wire fsp_fuse_s fuse_i,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output fsp_op_s flash_op_o,
	output logic op_done_o,
	output logic cpu_halt_o,
	output logic section_read_block_o,
	output logic [7:0] lock_bits_o,
	output logic irq_o
);

	// Index of a register behind a byte address
	function automatic logic is_idx(input logic [7:0] a,
		input logic [5:0] idx);
		is_idx = (a[7:2] == idx);
	endfunction

	// Write channel holding registers
	logic aw_have_q;
	logic [7:0] aw_addr_q;
	logic w_have_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	// Read channel registers
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// Software-visible state
	logic [7:0] csr_q; // prog_ctrl_status_reg
	logic [15:0] ptr_q; // Address pointer
	logic [7:0] data_low_reg_q;
	logic [7:0] data_high_reg_q;
	logic [7:0] lock_q; // Lock bits, zero means programmed
	logic [2:0] store_win_q; // Cycles left for a store
	logic [2:0] load_win_q; // Cycles left for a load

	// Sequencer state
	fsp_state_e state_q;
	logic [19:0] cnt_q;
	fsp_op_s op_q;
	logic [7:0] lock_data_q;

	// Decoded events
	logic wr_fire;
	logic rd_fire;
	logic csr_wr;
	logic store_evt;
	logic store_ok;
	logic load_evt;
	logic load_hit;
	logic [4:0] cmd;
	logic op_start;
	logic op_end;
	logic wr_map;
	logic rd_map;
	logic [7:0] load_byte;
	logic [6:0] page;

	// Handshake outputs straight from holding flags
	assign s_axi_awready = ~aw_have_q;
	assign s_axi_wready = ~w_have_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// A write completes once address and data are both held
	assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
	assign rd_fire = s_axi_arvalid & ~rvalid_q;
	assign wr_map = is_idx(aw_addr_q, `FSP_CSR_IDX)
		| is_idx(aw_addr_q, `FSP_PTR_IDX)
		| is_idx(aw_addr_q, `FSP_DATA_IDX)
		| is_idx(aw_addr_q, `FSP_CMD_IDX);
	assign rd_map = wr_map_rd(s_axi_araddr);

	// Readable addresses include the two read-only registers
	function automatic logic wr_map_rd(input logic [7:0] a);
		wr_map_rd = is_idx(a, `FSP_CSR_IDX) | is_idx(a, `FSP_PTR_IDX)
			| is_idx(a, `FSP_DATA_IDX) | is_idx(a, `FSP_LOAD_IDX)
			| is_idx(a, `FSP_STAT_IDX);
	endfunction

	assign cmd = csr_q[4:0];
	assign csr_wr = wr_fire & is_idx(aw_addr_q, `FSP_CSR_IDX) & w_strb_q[0];
	// Store instruction: bit 0 written to the command register
	assign store_evt = wr_fire & is_idx(aw_addr_q, `FSP_CMD_IDX)
		& w_strb_q[0] & w_data_q[0];
	// EEPROM write refuses every store
	assign store_ok = store_evt & csr_q[`FSP_CSR_EN] & (store_win_q != 3'h0)
		& (state_q == FSP_IDLE) & ~eeprom_write_busy_i;
	assign op_start = store_ok & ((cmd == `FSP_CMD_ERASE)
		| (cmd == `FSP_CMD_WRITE) | (cmd == `FSP_CMD_LOCK));
	assign op_end = (state_q == FSP_FINISH);
	// Program load: a read of the load register
	assign load_evt = rd_fire & is_idx(s_axi_araddr, `FSP_LOAD_IDX);
	assign load_hit = load_evt & (cmd == `FSP_CMD_LOCK)
		& (load_win_q != 3'h0) & ~eeprom_write_busy_i;
	// Page number only; word field ignored here
	assign page = ptr_q[`FSP_PAGE_MSB:`FSP_PAGE_LSB];

	// Byte returned by a program load
	always_comb begin
		load_byte = prog_rdata_i;
		if (load_hit) begin
			// Cells already hold zero for programmed bits
			if (ptr_q == `FSP_PTR_FUSE_LO) begin
				load_byte = fuse_i.low;
			end else if (ptr_q == `FSP_PTR_LOCK) begin
				load_byte = lock_q;
			end else if (ptr_q == `FSP_PTR_EXT) begin
				load_byte = fuse_i.ext;
			end else if (ptr_q == `FSP_PTR_FUSE_HI) begin
				load_byte = fuse_i.high;
			end
		end
	end

	// Write address and data taken in either order
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_have_q) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && !w_have_q) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// Write response; unmapped or read-only targets get SLVERR
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bvalid_q <= 1'b0;
			bresp_q <= `FSP_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_map ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read data, one cycle after the address is taken
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `FSP_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rresp_q <= rd_map ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
			rdata_q <= 32'h0000_0000;
			if (is_idx(s_axi_araddr, `FSP_CSR_IDX)) begin
				rdata_q[7:0] <= csr_q;
			end else if (is_idx(s_axi_araddr, `FSP_PTR_IDX)) begin
				rdata_q[15:0] <= ptr_q;
			end else if (is_idx(s_axi_araddr, `FSP_DATA_IDX)) begin
				rdata_q[15:0] <= {data_high_reg_q, data_low_reg_q};
			end else if (is_idx(s_axi_araddr, `FSP_LOAD_IDX)) begin
				rdata_q[7:0] <= load_byte;
			end else if (is_idx(s_axi_araddr, `FSP_STAT_IDX)) begin
				rdata_q[9:0] <= {eeprom_write_busy_i, op_q.busy, lock_q};
			end
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Pointer and data registers, byte lanes honoured
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ptr_q <= 16'h0000;
			data_low_reg_q <= 8'h00;
			data_high_reg_q <= 8'h00;
		end else if (wr_fire) begin
			if (is_idx(aw_addr_q, `FSP_PTR_IDX)) begin
				if (w_strb_q[0]) begin
					ptr_q[7:0] <= w_data_q[7:0];
				end
				if (w_strb_q[1]) begin
					ptr_q[15:8] <= w_data_q[15:8];
				end
			end else if (is_idx(aw_addr_q, `FSP_DATA_IDX)) begin
				if (w_strb_q[0]) begin
					data_low_reg_q <= w_data_q[7:0];
				end
				if (w_strb_q[1]) begin
					data_high_reg_q <= w_data_q[15:8];
				end
			end
		end
	end

	// Store and load windows opened by setting the enable bit
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			store_win_q <= 3'h0;
			load_win_q <= 3'h0;
		end else if (csr_wr && w_data_q[`FSP_CSR_EN]
			&& state_q == FSP_IDLE) begin
			store_win_q <= `FSP_STORE_WIN;
			load_win_q <= `FSP_LOAD_WIN;
		end else begin
			if (store_win_q != 3'h0) begin
				store_win_q <= store_win_q - 3'h1;
			end
			if (load_win_q != 3'h0) begin
				load_win_q <= load_win_q - 3'h1;
			end
		end
	end

	// Control/status register; CPU reset spares a running write
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			csr_q <= `FSP_CSR_RST;
		end else if (state_q != FSP_IDLE) begin
			// Enable and command held until the end
			if (op_end) begin
				csr_q[4:0] <= 5'h00;
			end
			if (cpu_rst_i) begin
				csr_q[`FSP_CSR_IE] <= 1'b0;
			end else if (csr_wr) begin
				csr_q[`FSP_CSR_IE] <= w_data_q[`FSP_CSR_IE];
			end
		end else if (cpu_rst_i) begin
			// Busy flag kept: section still needs re-enable
			csr_q[`FSP_CSR_IE] <= 1'b0;
			csr_q[4:0] <= 5'h00;
		end else if (csr_wr) begin
			// Busy bit and bit 5 are read-only
			csr_q[`FSP_CSR_IE] <= w_data_q[`FSP_CSR_IE];
			csr_q[4:0] <= w_data_q[4:0];
		end else if (op_start) begin
			// Readable section unavailable from here on
			if (cmd != `FSP_CMD_LOCK) begin
				csr_q[`FSP_CSR_BUSY] <= 1'b1;
			end
		end else if (store_ok) begin
			// Immediate commands finish at once
			if (cmd == `FSP_CMD_REEN) begin
				csr_q[`FSP_CSR_BUSY] <= 1'b0;
			end
			csr_q[4:0] <= 5'h00;
		end else if (load_hit) begin
			csr_q[4:0] <= 5'h00;
		end else if (store_win_q == 3'h1 || store_evt) begin
			// Window lapsed or store refused; drop the request
			csr_q[4:0] <= 5'h00;
		end
	end

	// Timed operation sequencer; only power-on reset stops it
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= FSP_IDLE;
			cnt_q <= 20'h00000;
		end else begin
			case (state_q)
				FSP_IDLE: begin
					if (op_start) begin
						state_q <= FSP_RUN;
						cnt_q <= 20'(WRITE_CYCLES - 1);
					end
				end
				FSP_RUN: begin
					// Ignores cpu_rst_i on purpose
					if (cnt_q == 20'h00000) begin
						state_q <= FSP_FINISH;
					end else begin
						cnt_q <= cnt_q - 20'h00001;
					end
				end
				default: begin
					state_q <= FSP_IDLE;
				end
			endcase
		end
	end

	// Operation latched at the start, so the pointer is free after
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			op_q <= '0;
			lock_data_q <= `FSP_LOCK_RST;
		end else if (op_start) begin
			op_q.busy <= 1'b1;
			op_q.page <= page;
			// Halting section when page is at or past the limit
			op_q.halting <= (cmd != `FSP_CMD_LOCK)
				&& (page >= `FSP_HALT_PAGE_MIN);
			lock_data_q <= data_low_reg_q;
			if (cmd == `FSP_CMD_ERASE) begin
				op_q.kind <= FSP_OP_ERASE;
			end else if (cmd == `FSP_CMD_WRITE) begin
				op_q.kind <= FSP_OP_WRITE;
			end else begin
				op_q.kind <= FSP_OP_LOCK;
			end
		end else if (op_end) begin
			op_q <= '0;
		end
	end

	// Lock cells only ever move towards programmed
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lock_q <= `FSP_LOCK_RST;
		end else if (op_end && op_q.kind == FSP_OP_LOCK) begin
			// A one leaves the bit alone
			lock_q <= lock_q & (lock_data_q | ~`FSP_LOCK_MASK);
		end
	end

	// Completion pulse, registered
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			op_done_o <= 1'b0;
		end else begin
			op_done_o <= op_end;
		end
	end

	// Outputs from flops; halt only for the halting section
	assign flash_op_o = op_q;
	assign cpu_halt_o = op_q.halting;
	assign section_read_block_o = csr_q[`FSP_CSR_BUSY];
	assign lock_bits_o = lock_q;
	// Level request while enable reads clear
	assign irq_o = csr_q[`FSP_CSR_IE] & global_irq_en_i
		& ~csr_q[`FSP_CSR_EN];

endmodule // fsp_ctrl

// ===== tb/fsp_ctrl_assertions.sv
// Port-level checks of the flash self-programming controller.
// Assumes it is bound into fsp_ctrl and sees one clock domain.
`timescale 1ns/10ps
module fsp_ctrl_assertions
	import fsp_pkg::*;
#(
	parameter int WRITE_CYCLES = 20 // Operation length in cycles
) (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic global_irq_en_i,
	input wire fsp_op_s flash_op_o,
	input wire logic op_done_o,
	input wire logic cpu_halt_o,
	input wire logic section_read_block_o,
	input wire logic [7:0] lock_bits_o,
	input wire logic irq_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	logic wr_op; // Erase or write under way
	logic [31:0] run_q; // Busy cycles of the current operation
	assign wr_op = flash_op_o.busy && flash_op_o.kind != FSP_OP_LOCK;
	// Busy length counter, since a repetition cannot span the whole op
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_q <= 32'h0;
		end else if (flash_op_o.busy) begin
			run_q <= run_q + 32'h1;
		end else begin
			run_q <= 32'h0;
		end
	end
	a_irq_gie: assert property (!global_irq_en_i |-> !irq_o)
		else $error("irq without global enable");
	a_irq_busy: assert property (flash_op_o.busy |-> !irq_o)
		else $error("irq while operation runs");
	a_halt_section: assert property (wr_op |->
		cpu_halt_o == (flash_op_o.page >= 7'h70))
		else $error("halt does not follow target section");
	a_halt_cause: assert property (cpu_halt_o |-> wr_op)
		else $error("halt without erase or write");
	a_busy_blocks: assert property (wr_op && $past(wr_op) |->
		section_read_block_o)
		else $error("section not blocked during op");
	a_op_length: assert property ($fell(flash_op_o.busy) |->
		run_q == WRITE_CYCLES + 1)
		else $error("operation length wrong");
	a_done_follows: assert property ($fell(flash_op_o.busy) |->
		##[0:1] op_done_o)
		else $error("no done pulse after operation");
	a_done_pulse: assert property (op_done_o |=> !op_done_o)
		else $error("done longer than one cycle");
	a_lock_oneway: assert property (
		(lock_bits_o & ~$past(lock_bits_o)) == 8'h00)
		else $error("lock bit returned to unprogrammed");
	a_lock_top: assert property (lock_bits_o[7:6] == 2'h3)
		else $error("lock byte top bits not one");
	c_halting_op: cover property (cpu_halt_o && flash_op_o.busy);
	// Kind is cleared with busy, so look while the lock write runs
	c_lock_op: cover property (flash_op_o.busy
		&& flash_op_o.kind == FSP_OP_LOCK);
	c_irq_seen: cover property (irq_o);
endmodule // fsp_ctrl_assertions

bind fsp_ctrl fsp_ctrl_assertions #(
	.WRITE_CYCLES(WRITE_CYCLES)
) u_chk (
	.core_clk_i(core_clk_i),
	.arst_n_i(arst_n_i),
	.global_irq_en_i(global_irq_en_i),
	.flash_op_o(flash_op_o),
	.op_done_o(op_done_o),
	.cpu_halt_o(cpu_halt_o),
	.section_read_block_o(section_read_block_o),
	.lock_bits_o(lock_bits_o),
	.irq_o(irq_o)
);

// ===== tb/fsp_mem_model.sv
// Program memory and fuse cells facing the controller.
// Assumes the bench uses the same parameters for expectations.
`timescale 1ns/10ps
module fsp_mem_model
	import fsp_pkg::*;
#(
	parameter logic [7:0] PROG = 8'h5A, // Byte at any pointer
	parameter fsp_fuse_s FUSE = 24'hE2D9F7 // Arbitrary cell pattern
) (
	output fsp_fuse_s fuse_o,
	output logic [7:0] prog_rdata_o
);
	// Cells read zero when programmed, one when not
	assign fuse_o = FUSE;
	// Static byte; the load path must pick it outside fuse mode
	assign prog_rdata_o = PROG;
endmodule // fsp_mem_model

// ===== tb/test_flash_self_program_ctrl.sv
// Self-checking bench of the flash self-programming controller.
// Assumes a shortened operation length and the memory model.
`timescale 1ns/10ps
`include "fsp_regs.svh"
module test_flash_self_program_ctrl
	import fsp_pkg::*;
;
	localparam int WC = 20; // Shortened operation length
	localparam logic [7:0] PROG = 8'h5A;
	localparam fsp_fuse_s FZ = 24'hE2D9F7;
	localparam logic [7:0] A_CSR = {`FSP_CSR_IDX, 2'h0};
	localparam logic [7:0] A_PTR = {`FSP_PTR_IDX, 2'h0};
	localparam logic [7:0] A_DATA = {`FSP_DATA_IDX, 2'h0};
	localparam logic [7:0] A_CMD = {`FSP_CMD_IDX, 2'h0};
	localparam logic [7:0] A_LOAD = {`FSP_LOAD_IDX, 2'h0};
	localparam logic [7:0] A_STAT = {`FSP_STAT_IDX, 2'h0};
	logic core_clk_i = 1'h0;
	logic arst_n_i = 1'h0;
	logic cpu_rst = 1'h0, gie = 1'h0, ee = 1'h0;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0, lkb, prog;
	// Responses always accepted, so ready never toggles between calls
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1;
	logic arvalid = 1'h0, rready = 1'h1;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid;
	logic done, halt, blk, irq;
	fsp_op_s op;
	fsp_fuse_s fuse;
	int miscompares = 0, n_checks = 0, lk = 255, bcnt = 0;
	logic [31:0] seed = 32'h0000DE4C;
	always #2.5 core_clk_i = ~core_clk_i;
	// Busy cycles of the latest operation, counted mid-cycle
	always @(negedge core_clk_i) begin
		if (op.busy === 1'h1)
			bcnt++;
	end
	fsp_mem_model #(.PROG(PROG), .FUSE(FZ)) i_mem (
		.fuse_o(fuse),
		.prog_rdata_o(prog)
	);
	fsp_ctrl #(.WRITE_CYCLES(WC)) i_dut (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.cpu_rst_i(cpu_rst),
		.global_irq_en_i(gie),
		.eeprom_write_busy_i(ee),
		.prog_rdata_i(prog),
		.fuse_i(fuse),
		.s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.flash_op_o(op),
		.op_done_o(done),
		.cpu_halt_o(halt),
		.section_read_block_o(blk),
		.lock_bits_o(lkb),
		.irq_o(irq)
	);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] g, e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic hang();
		chk("wait bound", 1'h0, 1'h1);
		print_verdict();
	endtask
	// Write: sample handshakes mid-cycle, release right after the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = `FSP_RESP_OKAY);
		bit ta, tw, tb;
		logic [1:0] r;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		tb = 0;
		for (int n = 0; n < 50 && !tb; n++) begin
			@(negedge core_clk_i);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge core_clk_i);
			if (ta)
				awvalid <= 1'h0;
			if (tw)
				wvalid <= 1'h0;
		end
		if (!tb)
			hang();
		chk("bresp", r, er);
	endtask
	// Read and compare data and response
	task automatic rdc(input logic [7:0] a, input string nm,
		input logic [31:0] e, input logic [1:0] er = `FSP_RESP_OKAY);
		bit ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		araddr <= a;
		arvalid <= 1'h1;
		tr = 0;
		for (int n = 0; n < 50 && !tr; n++) begin
			@(negedge core_clk_i);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge core_clk_i);
			if (ta)
				arvalid <= 1'h0;
		end
		if (!tr)
			hang();
		chk(nm, d, e);
		chk("rresp", r, er);
	endtask
	// Timed window reads at pointers 0000 to 0003; enable and set bits clear on the load
	task automatic fuse_rd();
		int e[4];
		e = '{FZ.low, lk, FZ.ext, FZ.high};
		for (int p = 0; p < 4; p++) begin
			wr(A_PTR, p);
			wr(A_CSR, 32'h09);
			rdc(A_LOAD, "fuse", e[p]);
			rdc(A_CSR, "auto clear", 32'h0);
			rdc(A_LOAD, "prog", PROG);
		end
	endtask
	// One timed operation; software side keeps pointer and data rules
	task automatic run_op(input logic [15:0] p, input logic [4:0] c,
		input logic [7:0] d, input logic rs);
		int n;
		logic lck;
		lck = c == `FSP_CMD_LOCK;
		rdc(A_STAT, "idle", lk);
		wr(A_PTR, p);
		wr(A_DATA, d);
		wr(A_CSR, c);
		bcnt = 0;
		wr(A_CMD, 32'h1);
		for (n = 0; n < 8 && op.busy !== 1'h1; n++)
			@(negedge core_clk_i);
		// Operation never started: count it and stop
		if (n == 8)
			hang();
		@(posedge core_clk_i);
		wr(A_CSR, 32'h80);
		chk("kind", op.kind, c[3:2]);
		chk("page", op.page, p[13:7]);
		chk("halt", halt, !lck && p[13:7] >= 7'h70);
		chk("block", blk, !lck);
		for (n = 0; done !== 1'h1 && n < 999; n++) begin
			@(posedge core_clk_i);
			cpu_rst <= rs && n == 4;
			@(negedge core_clk_i);
		end
		if (n == 999)
			hang();
		@(posedge core_clk_i);
		chk("length", bcnt, WC + 1);
		chk("irq", irq, gie && !rs);
		if (lck)
			lk = lk & (d | 8'hC0);
		chk("lock", lkb, lk);
		rdc(A_CSR, "csr end", {!rs, !lck, 6'h0});
		wr(A_CSR, 32'h0);
		wr(A_CSR, `FSP_CMD_REEN);
		wr(A_CMD, 32'h1);
		rdc(A_CSR, "reenable", 32'h0);
		chk("unblock", blk, 1'h0);
	endtask
	initial begin
		logic [31:0] r;
		logic [4:0] cm[5];
		cm = '{`FSP_CMD_WRITE, `FSP_CMD_ERASE, `FSP_CMD_LOCK,
			`FSP_CMD_LOCK, `FSP_CMD_WRITE};
		repeat (3) @(posedge core_clk_i);
		arst_n_i <= 1'h1;
		@(posedge core_clk_i);
		rdc(A_CSR, "csr reset", 32'h0);
		rdc(A_STAT, "stat reset", 32'hFF);
		rdc(8'h00, "unmapped", 32'h0, `FSP_RESP_SLVERR);
		fuse_rd();
		wr(A_CSR, 32'h09);
		repeat (4) @(posedge core_clk_i);
		rdc(A_CSR, "lapse", 32'h0);
		rdc(A_LOAD, "lapse load", PROG);
		ee <= 1'h1;
		wr(A_CSR, `FSP_CMD_WRITE);
		wr(A_CMD, 32'h1);
		rdc(A_STAT, "ee refuse", 32'h200 | lk);
		// Fuse read inside an open window is refused as well
		wr(A_CSR, 32'h09);
		rdc(A_LOAD, "ee load", PROG);
		ee <= 1'h0;
		for (int i = 0; i < 5; i++) begin
			r = xs();
			gie <= i < 4;
			@(posedge core_clk_i);
			run_op(cm[i] == `FSP_CMD_LOCK ? 16'h0001 :
				{2'h0, i[0] ? 7'h70 | r[3:0] : r[6:0] % 7'h70, 7'h0},
				cm[i], r[15:8] | 8'hC0, i == 1);
		end
		// Protect the boot section by programming its write lock
		run_op(16'h0001, `FSP_CMD_LOCK, 8'hEF, 1'h0);
		fuse_rd();
		print_verdict();
	end
endmodule // test_flash_self_program_ctrl
